//--- dual_serial_pkg.sv
/*
   constants shared by the dual serial port block: port offsets, field
   positions, reset values and base clock rates.
   assumes a single 10 MHz system clock.
*/
package dual_serial_pkg;
   localparam int SYS_CLK_HZ = 10_000_000;
   localparam int BASE_EXT_HZ = 2_000_000;
   localparam int BASE_OSC_HZ = 1_228_800;
   localparam int PHASE_UNIT_HZ = 100;
   localparam logic [16:0] PHASE_MOD = 17'(SYS_CLK_HZ / PHASE_UNIT_HZ);
   localparam logic [16:0] PHASE_INC_EXT = 17'(BASE_EXT_HZ / PHASE_UNIT_HZ);
   localparam logic [16:0] PHASE_INC_OSC = 17'(BASE_OSC_HZ / PHASE_UNIT_HZ);
   localparam int OVERSAMPLE_DEFAULT = 16;
   localparam int NUM_COUNTERS = 3;
   localparam logic [3:0] OFS_CHAN_CTRL [2] = '{4'h0, 4'h2};
   localparam logic [3:0] OFS_CHAN_DATA [2] = '{4'h1, 4'h3};
   localparam logic [3:0] OFS_TIMER0 = 4'h4;
   localparam logic [3:0] OFS_TIMER_MODE = 4'h7;
   localparam logic [3:0] OFS_BOARD_CTRL = 4'h8;
   localparam logic [3:0] OFS_TICK_CLEAR = 4'h9;
   localparam int BC_ROM_DISABLE = 0;
   localparam int BC_TICK_IE = 1;
   localparam int BC_TX_IE [2] = '{5, 2};
   localparam int BC_RX_IE [2] = '{6, 3};
   localparam int BC_RTS [2] = '{7, 4};
   localparam int CC_PAR_INHIBIT = 0;
   localparam int CC_EVEN = 1;
   localparam int CC_STOP = 2;
   localparam int CC_LEN_LSB = 3;
   localparam int ST_CTS = 7;
   localparam int MW_SEL_LSB = 6;
   localparam int MW_RW_LSB = 4;
   localparam logic [7:0] BOARD_CTRL_RESET = 8'h00;
   localparam logic [4:0] CHAN_CFG_RESET = 5'h19;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   typedef enum logic [1:0] {
      RW_LATCH = 2'h0,
      RW_LSB = 2'h1,
      RW_MSB = 2'h2,
      RW_BOTH = 2'h3
   } rw_mode_t;
endpackage

//--- serial_chan_if.sv
/*
   carrier between the port decoder and one serial channel.
   assumes both ends run on sys_clk; strobes are one-cycle pulses.
*/
`timescale 1ns/1ps
interface serial_chan_if;
   logic baudTick;
   logic cfgWrite;
   logic [4:0] cfgData;
   logic txWrite;
   logic [7:0] txData;
   logic rxRead;
   logic [4:0] status;
   logic [7:0] rxData;
   modport ctrl (output baudTick, cfgWrite, cfgData, txWrite, txData, rxRead,
      input status, rxData);
   modport chan (input baudTick, cfgWrite, cfgData, txWrite, txData, rxRead,
      output status, rxData);
endinterface

//--- serial_channel.sv
/*
   one asynchronous serial channel: double-buffered transmitter and receiver.
   assumes baudTick pulses at OVERSAMPLE times the bit rate and rxd is
   already synchronous to sys_clk.
*/
`timescale 1ns/1ps
module serial_channel
   import dual_serial_pkg::*;
#(
   parameter int OVERSAMPLE = OVERSAMPLE_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst,
   serial_chan_if.chan port,
   input wire logic rxd,
   output logic txd
);
   typedef enum {S_IDLE, S_START, S_DATA, S_PARITY, S_STOP} frame_state_t;
   if (OVERSAMPLE < 4 || OVERSAMPLE > 32 || (OVERSAMPLE % 2) != 0) begin : g_check
      $error("OVERSAMPLE must be even and within 4 to 32");
   end
   localparam logic [6:0] BIT_END = 7'(OVERSAMPLE - 1);
   localparam logic [6:0] HALF_END = 7'(OVERSAMPLE / 2 - 1);
   localparam logic [6:0] STOP15_END = 7'(OVERSAMPLE * 3 / 2 - 1);
   localparam logic [6:0] STOP2_END = 7'(OVERSAMPLE * 2 - 1);

   function automatic logic [2:0] lastBit(input logic [1:0] lenCode);
      return 3'(lenCode) + 3'h4;
   endfunction

   function automatic logic parityOf(input logic [7:0] d, input logic [1:0] lenCode,
         input logic even);
      logic [7:0] m;
      m = d & (8'hff >> (3'h3 - 3'(lenCode)));
      return even ? ^m : ~^m;
   endfunction

   logic [4:0] cfg, next_cfg;
   frame_state_t txState, next_txState, rxState, next_rxState;
   logic [6:0] txCnt, next_txCnt, rxCnt, next_rxCnt, stopEnd;
   logic [2:0] txBit, next_txBit, rxBit, next_rxBit;
   logic [7:0] txShift, next_txShift, txHold, next_txHold;
   logic [7:0] rxShift, next_rxShift, rxHold, next_rxHold;
   logic txEmpty, next_txEmpty, txPar, next_txPar, next_txd;
   logic rxPar, next_rxPar, rxReady, next_rxReady;
   logic parErr, next_parErr, frameErr, next_frameErr, overrun, next_overrun;
   wire logic [1:0] lenCode = cfg[CC_LEN_LSB +: 2];

   // 1.5 stop bits only for 5-bit characters
   assign stopEnd = !cfg[CC_STOP] ? BIT_END : (lenCode == 2'h0 ? STOP15_END : STOP2_END);

   always_comb begin
      next_cfg = port.cfgWrite ? port.cfgData : cfg;
      next_txState = txState;
      next_txCnt = txCnt;
      next_txBit = txBit;
      next_txShift = txShift;
      next_txHold = txHold;
      next_txEmpty = txEmpty;
      next_txPar = txPar;
      next_txd = txd;
      if (port.baudTick) begin
         next_txCnt = txCnt + 7'h1;
         case (txState)
            S_IDLE: begin
               next_txCnt = 7'h0;
               if (!txEmpty) begin
                  next_txShift = txHold;
                  next_txPar = parityOf(txHold, lenCode, cfg[CC_EVEN]);
                  next_txEmpty = 1'b1;
                  next_txState = S_START;
                  next_txd = 1'b0;
               end
            end
            S_START: if (txCnt == BIT_END) begin
               next_txCnt = 7'h0;
               next_txBit = 3'h0;
               next_txState = S_DATA;
               next_txd = txShift[0];
            end
            S_DATA: if (txCnt == BIT_END) begin
               next_txCnt = 7'h0;
               next_txBit = txBit + 3'h1;
               if (txBit == lastBit(lenCode)) begin
                  next_txState = cfg[CC_PAR_INHIBIT] ? S_STOP : S_PARITY;
                  next_txd = cfg[CC_PAR_INHIBIT] ? 1'b1 : txPar;
               end else begin
                  next_txd = txShift[3'(txBit + 3'h1)];
               end
            end
            S_PARITY: if (txCnt == BIT_END) begin
               next_txCnt = 7'h0;
               next_txState = S_STOP;
               next_txd = 1'b1;
            end
            S_STOP: if (txCnt == stopEnd) begin
               next_txCnt = 7'h0;
               next_txState = S_IDLE;
            end
            default: next_txState = S_IDLE;
         endcase
      end
      // a write during the hand-off keeps the new byte held
      if (port.txWrite) begin
         next_txHold = port.txData;
         next_txEmpty = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cfg <= CHAN_CFG_RESET;
         txState <= S_IDLE;
         txCnt <= 7'h0;
         txBit <= 3'h0;
         txShift <= 8'h00;
         txHold <= 8'h00;
         txEmpty <= 1'b1;
         txPar <= 1'b0;
         txd <= 1'b1;
      end else begin
         cfg <= next_cfg;
         txState <= next_txState;
         txCnt <= next_txCnt;
         txBit <= next_txBit;
         txShift <= next_txShift;
         txHold <= next_txHold;
         txEmpty <= next_txEmpty;
         txPar <= next_txPar;
         txd <= next_txd;
      end
   end

   always_comb begin
      next_rxState = rxState;
      next_rxCnt = rxCnt;
      next_rxBit = rxBit;
      next_rxShift = rxShift;
      next_rxHold = rxHold;
      next_rxPar = rxPar;
      next_rxReady = rxReady;
      next_parErr = parErr;
      next_frameErr = frameErr;
      next_overrun = overrun;
      if (port.rxRead) begin
         next_rxReady = 1'b0;
         next_overrun = 1'b0;
      end
      if (port.baudTick) begin
         next_rxCnt = rxCnt + 7'h1;
         case (rxState)
            S_IDLE: begin
               next_rxCnt = 7'h0;
               if (!rxd)
                  next_rxState = S_START;
            end
            // a start bit gone high by mid-bit is a glitch
            S_START: if (rxCnt == HALF_END) begin
               next_rxCnt = 7'h0;
               next_rxBit = 3'h0;
               next_rxShift = 8'h00;
               next_rxState = rxd ? S_IDLE : S_DATA;
            end
            S_DATA: if (rxCnt == BIT_END) begin
               next_rxCnt = 7'h0;
               next_rxShift[rxBit] = rxd;
               next_rxBit = rxBit + 3'h1;
               if (rxBit == lastBit(lenCode))
                  next_rxState = cfg[CC_PAR_INHIBIT] ? S_STOP : S_PARITY;
            end
            S_PARITY: if (rxCnt == BIT_END) begin
               next_rxCnt = 7'h0;
               next_rxPar = rxd;
               next_rxState = S_STOP;
            end
            // load wins over a read in the same cycle
            S_STOP: if (rxCnt == BIT_END) begin
               next_rxCnt = 7'h0;
               next_rxState = S_IDLE;
               next_rxHold = rxShift;
               next_rxReady = 1'b1;
               next_overrun = rxReady && !port.rxRead;
               next_frameErr = !rxd;
               next_parErr = !cfg[CC_PAR_INHIBIT] &&
                  (rxPar != parityOf(rxShift, lenCode, cfg[CC_EVEN]));
            end
            default: next_rxState = S_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rxState <= S_IDLE;
         rxCnt <= 7'h0;
         rxBit <= 3'h0;
         rxShift <= 8'h00;
         rxHold <= 8'h00;
         rxPar <= 1'b0;
         rxReady <= 1'b0;
         parErr <= 1'b0;
         frameErr <= 1'b0;
         overrun <= 1'b0;
      end else begin
         rxState <= next_rxState;
         rxCnt <= next_rxCnt;
         rxBit <= next_rxBit;
         rxShift <= next_rxShift;
         rxHold <= next_rxHold;
         rxPar <= next_rxPar;
         rxReady <= next_rxReady;
         parErr <= next_parErr;
         frameErr <= next_frameErr;
         overrun <= next_overrun;
      end
   end

   assign port.status = {overrun, frameErr, parErr, txEmpty, rxReady};
   assign port.rxData = rxHold;

   a_tx_start_low: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(txState == S_START) |-> !txd && (txEmpty || $past(port.txWrite)))
      else $error("start bit not driven low");
   a_rx_frame_load: assert property (@(posedge sys_clk) disable iff (rst)
      (rxState == S_STOP && port.baudTick && rxCnt == BIT_END)
         |=> rxReady && rxHold == $past(rxShift) && frameErr == !$past(rxd))
      else $error("received character not loaded");
endmodule

//--- dual_serial_io_port.sv
/*
   dual serial port with shared port control byte and three-counter timer,
   reached through a 16-port I/O window.
   assumes ioWrite/ioRead are one-cycle strobes synchronous to sys_clk.
*/
// Summary of operation
// - receiver deserializes frames, checks parity and stop bit.
// - transmitter sends start, data, optional parity and stop bits.
// - both directions have a holding register beside the shift register.
// - character length is 5, 6, 7 or 8 bits.
// - parity may be inhibited; otherwise odd or even.
// - one or two stop bits; two with 5-bit characters gives 1.5.
// - bit rate 75 to 19.2K, from the channel's timer counter.
// - control bit 0 disables ROM, bit 1 enables tick interrupt.
// - control bits 2,3 channel 1 tx/rx interrupt enables, bit 4 its RTS.
// - control bits 5,6 channel 0 tx/rx interrupt enables, bit 7 its RTS.
// - any write to offset 9 clears the pending tick interrupt.
// - channel control write: parity inhibit, even parity, stop, length.
// - channel status read: ready, empty, parity, framing, overrun, CTS.
// - data port write loads transmit holding, read returns received byte.
// - channel 1 uses ports 2 and 3, laid out like channel 0.
// - counter 0 and 1 give baud clocks, counter 2 the tick.
// - each counter divides the base clock by its loaded factor.
// - base clock is 2 MHz or 1.2288 MHz by jumper.
// - port drives transmit data and RTS, receives data and CTS.
// - 16-port window, upper address nibble from jumpers.
`timescale 1ns/1ps
module dual_serial_io_port
   import dual_serial_pkg::*;
#(
   parameter int OVERSAMPLE = OVERSAMPLE_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [7:0] ioAddr,
   input wire logic ioWrite,
   input wire logic ioRead,
   input wire logic [7:0] writeData,
   output logic [7:0] readData,
   input wire logic [3:0] boardAddressJumper,
   input wire logic timerClockSelectJumper,
   input wire logic romEnableJumper,
   input wire logic [1:0] rxd,
   input wire logic [1:0] cts,
   output logic [1:0] txd,
   output logic [1:0] rts,
   output logic [1:0] lineIrq,
   output logic tickIrq,
   output logic romSelect
);
   logic [7:0] boardCtrl, next_boardCtrl, next_readData;
   logic tickPending, next_tickPending;
   logic [16:0] phase, next_phase;
   logic baseTick, next_baseTick;
   logic [15:0] count [NUM_COUNTERS], next_count [NUM_COUNTERS];
   logic [15:0] reload [NUM_COUNTERS], next_reload [NUM_COUNTERS];
   rw_mode_t rwMode [NUM_COUNTERS], next_rwMode [NUM_COUNTERS];
   logic msbNext [NUM_COUNTERS], next_msbNext [NUM_COUNTERS];
   logic armed [NUM_COUNTERS], next_armed [NUM_COUNTERS];
   logic outTick [NUM_COUNTERS];
   logic [4:0] chanStatus [2];
   logic [7:0] chanRxData [2];
   logic [1:0] chanRxReady, chanTxEmpty;

   // only the upper nibble is compared, so the window is always 16 ports
   wire logic hit = (ioAddr[7:4] == boardAddressJumper);
   wire logic [3:0] offset = ioAddr[3:0];
   wire logic wrStrobe = ioWrite && hit;
   wire logic rdStrobe = ioRead && hit;
   wire logic modeWr = wrStrobe && offset == OFS_TIMER_MODE;
   wire logic [1:0] mwSel = writeData[MW_SEL_LSB +: 2];
   wire logic [1:0] mwRw = writeData[MW_RW_LSB +: 2];
   wire logic [16:0] phaseInc = timerClockSelectJumper ? PHASE_INC_EXT : PHASE_INC_OSC;

   serial_chan_if chan [2] ();

   for (genvar g = 0; g < 2; g++) begin : g_chan
      assign chan[g].baudTick = outTick[g];
      assign chan[g].cfgWrite = wrStrobe && offset == OFS_CHAN_CTRL[g];
      assign chan[g].cfgData = writeData[4:0];
      assign chan[g].txWrite = wrStrobe && offset == OFS_CHAN_DATA[g];
      assign chan[g].txData = writeData;
      assign chan[g].rxRead = rdStrobe && offset == OFS_CHAN_DATA[g];
      assign chanStatus[g] = chan[g].status;
      assign chanRxData[g] = chan[g].rxData;
      assign chanRxReady[g] = chan[g].status[0];
      assign chanTxEmpty[g] = chan[g].status[1];
      serial_channel #(
         .OVERSAMPLE(OVERSAMPLE)
      ) u_channel (
         .sys_clk(sys_clk),
         .rst(rst),
         .port(chan[g]),
         .rxd(rxd[g]),
         .txd(txd[g])
      );
      assign rts[g] = boardCtrl[BC_RTS[g]];
      assign lineIrq[g] = (chanRxReady[g] && boardCtrl[BC_RX_IE[g]]) ||
         (chanTxEmpty[g] && boardCtrl[BC_TX_IE[g]]);
   end

   assign tickIrq = tickPending && boardCtrl[BC_TICK_IE];
   assign romSelect = romEnableJumper && !boardCtrl[BC_ROM_DISABLE];

   always_comb begin
      next_boardCtrl = boardCtrl;
      if (wrStrobe && offset == OFS_BOARD_CTRL)
         next_boardCtrl = writeData;
      next_tickPending = tickPending;
      // data value is ignored; a tick in the same cycle still sets
      if (wrStrobe && offset == OFS_TICK_CLEAR)
         next_tickPending = 1'b0;
      if (outTick[2])
         next_tickPending = 1'b1;
      next_readData = readData;
      if (rdStrobe) begin
         case (offset)
            OFS_CHAN_CTRL[0]: next_readData = {cts[0], 2'h0, chanStatus[0]};
            OFS_CHAN_DATA[0]: next_readData = chanRxData[0];
            OFS_CHAN_CTRL[1]: next_readData = {cts[1], 2'h0, chanStatus[1]};
            OFS_CHAN_DATA[1]: next_readData = chanRxData[1];
            OFS_TIMER0: next_readData = count[0][7:0];
            OFS_TIMER0 + 4'h1: next_readData = count[1][7:0];
            OFS_TIMER0 + 4'h2: next_readData = count[2][7:0];
            default: next_readData = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         boardCtrl <= BOARD_CTRL_RESET;
         tickPending <= 1'b0;
         readData <= 8'h00;
      end else begin
         boardCtrl <= next_boardCtrl;
         tickPending <= next_tickPending;
         readData <= next_readData;
      end
   end

   always_comb begin
      // fractional accumulator gives an exact mean base rate from sys_clk
      next_phase = phase + phaseInc;
      next_baseTick = 1'b0;
      if (next_phase >= PHASE_MOD) begin
         next_phase = next_phase - PHASE_MOD;
         next_baseTick = 1'b1;
      end
      for (int i = 0; i < NUM_COUNTERS; i++) begin
         next_count[i] = count[i];
         next_reload[i] = reload[i];
         next_rwMode[i] = rwMode[i];
         next_msbNext[i] = msbNext[i];
         next_armed[i] = armed[i];
         // a zero factor counts the full 65536
         outTick[i] = baseTick && armed[i] && count[i] == 16'h0001;
         if (baseTick && armed[i])
            next_count[i] = outTick[i] ? reload[i] : count[i] - 16'h0001;
         if (modeWr && mwSel == 2'(i) && mwRw != RW_LATCH) begin
            next_rwMode[i] = rw_mode_t'(mwRw);
            next_msbNext[i] = (mwRw == RW_MSB);
            next_armed[i] = 1'b0;
         end
         if (wrStrobe && offset == OFS_TIMER0 + 4'(i)) begin
            if (msbNext[i]) begin
               next_reload[i] = {writeData, rwMode[i] == RW_BOTH ? reload[i][7:0] : 8'h00};
               next_count[i] = next_reload[i];
               next_msbNext[i] = (rwMode[i] == RW_MSB);
               next_armed[i] = 1'b1;
            end else begin
               next_reload[i] = {8'h00, writeData};
               if (rwMode[i] == RW_BOTH) begin
                  next_msbNext[i] = 1'b1;
                  next_armed[i] = 1'b0;
               end else begin
                  next_count[i] = next_reload[i];
                  next_armed[i] = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         phase <= 17'h0;
         baseTick <= 1'b0;
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            count[i] <= COUNT_RESET;
            reload[i] <= COUNT_RESET;
            rwMode[i] <= RW_BOTH;
            msbNext[i] <= 1'b0;
            armed[i] <= 1'b0;
         end
      end else begin
         phase <= next_phase;
         baseTick <= next_baseTick;
         for (int i = 0; i < NUM_COUNTERS; i++) begin
            count[i] <= next_count[i];
            reload[i] <= next_reload[i];
            rwMode[i] <= next_rwMode[i];
            msbNext[i] <= next_msbNext[i];
            armed[i] <= next_armed[i];
         end
      end
   end

   a_tick_sets: assert property (@(posedge sys_clk) disable iff (rst)
      outTick[2] |=> tickPending)
      else $error("terminal count did not set tick pending");
   a_tick_clears: assert property (@(posedge sys_clk) disable iff (rst)
      (wrStrobe && offset == OFS_TICK_CLEAR && !outTick[2]) |=> !tickPending && !tickIrq)
      else $error("tick clear write ignored");
   a_rts_zero: assert property (@(posedge sys_clk) disable iff (rst)
      (wrStrobe && offset == OFS_BOARD_CTRL) |=> rts[0] == $past(writeData[7]))
      else $error("channel 0 RTS does not follow control bit 7");
   a_rts_one: assert property (@(posedge sys_clk) disable iff (rst)
      (wrStrobe && offset == OFS_BOARD_CTRL) |=> rts[1] == $past(writeData[4]))
      else $error("channel 1 RTS does not follow control bit 4");
   a_rom_off: assert property (@(posedge sys_clk) disable iff (rst)
      (wrStrobe && offset == OFS_BOARD_CTRL && writeData[0]) |=> !romSelect)
      else $error("ROM still selected after disable");
   a_window_only: assert property (@(posedge sys_clk) disable iff (rst)
      (ioWrite && !hit) |=> $stable(boardCtrl) && $stable(reload[0]))
      else $error("write outside the window changed state");
   a_count_reload: assert property (@(posedge sys_clk) disable iff (rst)
      (outTick[0] && !wrStrobe && !modeWr) |=> count[0] == $past(reload[0]))
      else $error("counter 0 did not reload at terminal count");
   a_rx_irq: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(chanRxReady[0]) && boardCtrl[BC_RX_IE[0]] |-> lineIrq[0])
      else $error("receive interrupt missing");
   a_status_read: assert property (@(posedge sys_clk) disable iff (rst)
      (rdStrobe && offset == OFS_CHAN_CTRL[1])
         |=> readData == $past({cts[1], 2'h0, chanStatus[1]}))
      else $error("channel 1 status read wrong");
   a_data_read: assert property (@(posedge sys_clk) disable iff (rst)
      (rdStrobe && offset == OFS_CHAN_DATA[0]) |=> readData == $past(chanRxData[0]))
      else $error("channel 0 data read wrong");
   a_tick_mask: assert property (@(posedge sys_clk) disable iff (rst)
      !boardCtrl[BC_TICK_IE] |-> !tickIrq)
      else $error("tick interrupt not masked");
   a_tx_irq: assert property (@(posedge sys_clk) disable iff (rst)
      (chanTxEmpty[1] && boardCtrl[BC_TX_IE[1]]) |-> lineIrq[1])
      else $error("transmit interrupt missing");
   a_count_load: assert property (@(posedge sys_clk) disable iff (rst)
      (wrStrobe && offset == OFS_TIMER0 && msbNext[0] && rwMode[0] == RW_BOTH)
         |=> armed[0] && count[0] == $past({writeData, reload[0][7:0]}))
      else $error("counter 0 two-byte load wrong");
   a_mode_stops: assert property (@(posedge sys_clk) disable iff (rst)
      (modeWr && mwSel == 2'h2 && mwRw != RW_LATCH) |=> !armed[2])
      else $error("mode word did not stop counter 2");
   a_base_gap: assert property (@(posedge sys_clk) disable iff (rst)
      baseTick |=> !baseTick)
      else $error("base tick faster than half the system clock");
endmodule

//--- serial_terminal.sv
/*
   behavioural terminal on one serial line: collects framed bytes from
   the block's transmit pin and sends frames into its receive pin.
   assumes 8 data bits, no parity, one stop bit, BIT_CLKS sys_clk per bit.
*/
`timescale 1ns/1ps
module serial_terminal #(
   parameter int BIT_CLKS = 80
) (
   input wire logic sys_clk,
   input wire logic txLine,
   output logic rxLine
);
   logic [7:0] q[$];
   logic [7:0] got;
   int count;
   initial begin
      rxLine = 1'b1;
      count = 0;
   end
   // sample mid-bit, lsb first; a low stop bit is simply not counted
   always begin : listen
      @(negedge txLine);
      repeat (BIT_CLKS / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CLKS) @(posedge sys_clk);
         got[i] = txLine;
      end
      repeat (BIT_CLKS) @(posedge sys_clk);
      if (txLine) begin
         q.push_back(got);
         count++;
      end
   end
   // stopLvl low gives a broken frame on purpose
   task automatic send(input logic [7:0] d, input logic stopLvl);
      logic [9:0] f;
      f = {stopLvl, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxLine <= f[i];
         repeat (BIT_CLKS) @(posedge sys_clk);
      end
      rxLine <= 1'b1;
   endtask
endmodule

//--- tb_dual_serial_io_port.sv
/*
   self-checking bench for the dual serial port: board control, window
   decode, timer setup, serial transmit and receive, tick interrupt.
   assumes the window at 8'h10 and the 2 MHz base clock jumper.
*/
`timescale 1ns/1ps
module tb_dual_serial_io_port;
   import dual_serial_pkg::*;
   logic sys_clk, rst, ioWrite, ioRead, tcs, romEn, tickIrq, romSelect, lineB, rx1;
   logic [7:0] ioAddr, writeData, readData, rd, b;
   logic [7:0] bq [2];
   logic [1:0] cts, txd, rts, lineIrq;
   logic [7:0] pinView;
   int err_total, n_checks, k;
   assign pinView = {txd, romSelect, tickIrq, lineIrq, rts};
   dual_serial_io_port dual_serial_io_port_inst(.sys_clk(sys_clk), .rst(rst),
      .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .writeData(writeData),
      .readData(readData), .boardAddressJumper(4'h1), .timerClockSelectJumper(tcs),
      .romEnableJumper(romEn), .rxd({rx1, lineB}), .cts(cts), .txd(txd), .rts(rts),
      .lineIrq(lineIrq), .tickIrq(tickIrq), .romSelect(romSelect));
   // factor 1 on 2 MHz: 5 clocks a baud tick, 16 ticks a bit
   serial_terminal #(.BIT_CLKS(80)) serial_terminal_inst(.sys_clk(sys_clk),
      .txLine(txd[0]), .rxLine(lineB));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("checks=%0d errors=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // one strobe cycle; read data is taken once it has settled
   task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      ioAddr <= a;
      writeData <= d;
      ioWrite <= wr;
      ioRead <= !wr;
      @(posedge sys_clk);
      ioWrite <= 1'b0;
      ioRead <= 1'b0;
      @(posedge sys_clk);
      #1 rd = readData;
   endtask
   // software polls a status bit; a missing bit ends the run
   task automatic pollStatus(input int bitNo);
      for (int j = 0; j < 40; j++) begin
         io(1'b0, 8'h10, 8'h00);
         if (rd[bitNo] === 1'b1) return;
      end
      err_total++;
      conclude;
   endtask
   task automatic waitFrames(input int n);
      for (int j = 0; j < 3000; j++) begin
         if (serial_terminal_inst.count >= n) return;
         @(posedge sys_clk);
      end
      err_total++;
      conclude;
   endtask
   function automatic logic [7:0] ctrlPins(input logic [7:0] c);
      return {2'b11, romEn & ~c[0], 1'b0, c[2], c[5], c[4], c[7]};
   endfunction
   // frame 1 has a low stop bit; frame 2 is 7 data bits with even parity
   function automatic logic [7:0] rxStatus(input logic c, input int j, input logic [7:0] d);
      return {c, 3'b000, 1'(j == 1), 1'(j == 2 && d[7] != ^d[6:0]), 2'b11};
   endfunction
   initial begin
      k = $urandom(98);
      {rst, ioAddr, ioWrite, ioRead, writeData, tcs, rx1} = {1'b1, 18'h0, 2'b11};
      romEn = 1'($urandom);
      cts = 2'($urandom);
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      #1 chk(pinView, {2'b11, romEn, 5'h00});
      for (k = 0; k < 5; k++) begin
         b = (k == 4) ? 8'hff : 8'($urandom);
         io(1'b1, 8'h18, b);
         chk(pinView, ctrlPins(b));
      end
      io(1'b1, 8'h28, 8'h00);
      chk(pinView, ctrlPins(8'hff));
      io(1'b0, 8'h1a, 8'h00);
      chk(rd, 8'h00);
      io(1'b0, 8'h12, 8'h00);
      chk(rd, {cts[1], 7'h02});
      io(1'b1, 8'h18, 8'h00);
      io(1'b1, 8'h17, 8'h36);
      io(1'b1, 8'h14, 8'h01);
      io(1'b1, 8'h14, 8'h00);
      io(1'b1, 8'h10, 8'h19);
      for (k = 0; k < 2; k++) begin
         bq[k] = 8'($urandom);
         pollStatus(1);
         io(1'b1, 8'h11, bq[k]);
      end
      waitFrames(2);
      chk(serial_terminal_inst.q[0], bq[0]);
      chk(serial_terminal_inst.q[1], bq[1]);
      io(1'b1, 8'h18, 8'h40);
      for (int j = 0; j < 3; j++) begin
         b = 8'($urandom);
         if (j == 2) io(1'b1, 8'h10, 8'h12);
         // let the receiver settle after a broken stop bit
         repeat (20) @(posedge sys_clk);
         serial_terminal_inst.send(b, j != 1);
         pollStatus(0);
         chk(rd, rxStatus(cts[0], j, b));
         chk(pinView, {2'b11, romEn, 5'h04});
         io(1'b0, 8'h11, 8'h00);
         chk(rd, (j == 2) ? {1'b0, b[6:0]} : b);
      end
      b = 8'($urandom);
      io(1'b1, 8'h11, b);
      waitFrames(3);
      chk(serial_terminal_inst.q[2], {^b[6:0], b[6:0]});
      io(1'b1, 8'h17, 8'hb6);
      io(1'b1, 8'h16, 8'h02);
      io(1'b1, 8'h16, 8'h00);
      io(1'b1, 8'h18, 8'h02);
      for (k = 0; tickIrq !== 1'b1 && k < 200; k++) @(posedge sys_clk);
      chk({7'h0, tickIrq}, 8'h01);
      // stop counter 2 first so a fresh tick cannot race the clear
      io(1'b1, 8'h17, 8'hb6);
      io(1'b1, 8'h19, 8'($urandom));
      repeat (50) @(posedge sys_clk);
      chk({7'h0, tickIrq}, 8'h00);
      conclude;
   end
endmodule
